// >>> sxe_defines.svh
/*
  shared constants for the skip, table-read and extended-operation datapath:
  opcode encodings, flag bit positions, decimal-adjust figures, reset values.
  assumes it is included once per compile unit by bare name.
*/
`ifndef SXE_DEFINES_SVH
`define SXE_DEFINES_SVH

// ----------------------------------------------------------------------------
// flag positions in the status byte
// ----------------------------------------------------------------------------
`define SXE_FLAG_C       3'd0
`define SXE_FLAG_NC      3'd1
`define SXE_FLAG_Z       3'd2
`define SXE_FLAG_SW      3'd3
`define SXE_FLAG_SGC     3'd4

// ----------------------------------------------------------------------------
// figures
// ----------------------------------------------------------------------------
`define SXE_BYTE_ZERO    8'h00
`define SXE_BYTE_ONE     8'h01
`define SXE_NIB_NINE     4'h9
`define SXE_ADJ_LOW      8'h06
`define SXE_ADJ_HIGH     8'h60
`define SXE_STATUS_RST   8'h00
`define SXE_WREG_RST     8'h00
`define SXE_PTR_RST      8'h00
`define SXE_LAST_PAGE    8'hff

// ----------------------------------------------------------------------------
// operation codes presented by decode
// ----------------------------------------------------------------------------
`define SXE_OP_NOP       5'h00
`define SXE_OP_SKZLD     5'h01
`define SXE_OP_SZBIT     5'h02
`define SXE_OP_TRD       5'h03
`define SXE_OP_TRDL      5'h04
`define SXE_OP_ITRD      5'h05
`define SXE_OP_ITRDL     5'h06
`define SXE_OP_XORA      5'h07
`define SXE_OP_XORI      5'h08
`define SXE_OP_XORMEM    5'h09
`define SXE_OP_ADCA      5'h0a
`define SXE_OP_ADCM      5'h0b
`define SXE_OP_ADDA      5'h0c
`define SXE_OP_ADDM      5'h0d
`define SXE_OP_ANDA      5'h0e
`define SXE_OP_ANDM      5'h0f
`define SXE_OP_CLR       5'h10
`define SXE_OP_CLRBIT    5'h11
`define SXE_OP_CPL       5'h12
`define SXE_OP_CPLA      5'h13
`define SXE_OP_DAA       5'h14
`define SXE_OP_DEC       5'h15
`define SXE_OP_DECA      5'h16
`define SXE_OP_INC       5'h17
`define SXE_OP_INCA      5'h18

`endif

// >>> sxe_pkg.sv
/*
  types for the skip, table-read and extended-operation datapath.
  assumes sxe_defines.svh is available for constants.
*/
package sxe_pkg;

  typedef logic [4:0] sxe_op_t;

  typedef enum logic [2:0] {
    SXE_IDLE,
    SXE_DATA_WAIT,
    SXE_OPERAND,
    SXE_TABLE_WAIT,
    SXE_TABLE,
    SXE_SKIP
  } sxe_state_t;

endpackage : sxe_pkg

// >>> sxe_alu_if.sv
/*
  carrier between the sequencer and the arithmetic leaf: operands in,
  result and flag updates out.
  assumes both ends run on the same clock; the leaf is purely combinational.
*/
`timescale 1ns/1ps
interface sxe_alu_if;
  logic [4:0] op;
  logic [7:0] wreg;
  logic [7:0] opnd;
  logic [7:0] status;
  logic [2:0] bit_sel;
  logic [7:0] result;
  logic [7:0] status_new;

  modport core (output op, output wreg, output opnd, output status, output bit_sel,
                input result, input status_new);
  modport alu  (input op, input wreg, input opnd, input status, input bit_sel,
                output result, output status_new);
endinterface : sxe_alu_if

// >>> sxe_alu.sv
/*
  combinational arithmetic and logic for the extended operations.
  assumes op, operands and current status are stable during the execute cycle.
*/
`timescale 1ns/1ps
`include "sxe_defines.svh"
module sxe_alu
  import sxe_pkg::*;
(
  sxe_alu_if.alu a
);

  logic [8:0] sum;
  logic [4:0] low;
  logic [7:0] sum7;
  logic       cin;
  logic [7:0] adj;
  logic [8:0] dsum;
  logic [7:0] r;
  logic [7:0] s;

  always_comb
  begin
    cin  = (a.op == `SXE_OP_ADCA || a.op == `SXE_OP_ADCM) ? a.status[`SXE_FLAG_C] : 1'b0;
    sum  = {1'b0, a.wreg} + {1'b0, a.opnd} + {8'h00, cin};
    low  = {1'b0, a.wreg[3:0]} + {1'b0, a.opnd[3:0]} + {4'h0, cin};
    sum7 = {1'b0, a.wreg[6:0]} + {1'b0, a.opnd[6:0]} + {7'h00, cin};
    adj  = `SXE_BYTE_ZERO;
    if (a.wreg[3:0] > `SXE_NIB_NINE || a.status[`SXE_FLAG_NC])
    begin
      adj = adj | `SXE_ADJ_LOW;
    end
    if (a.wreg[7:4] > `SXE_NIB_NINE || a.status[`SXE_FLAG_C])
    begin
      adj = adj | `SXE_ADJ_HIGH;
    end
    dsum = {1'b0, a.wreg} + {1'b0, adj};
    r    = a.wreg;
    s    = a.status;
    case (a.op)
      `SXE_OP_XORA, `SXE_OP_XORI, `SXE_OP_XORMEM:
      begin
        r = a.wreg ^ a.opnd;
        s[`SXE_FLAG_Z] = (r == `SXE_BYTE_ZERO);
      end
      `SXE_OP_ADCA, `SXE_OP_ADCM, `SXE_OP_ADDA, `SXE_OP_ADDM:
      begin
        r = sum[7:0];
        s[`SXE_FLAG_C]  = sum[8];
        s[`SXE_FLAG_NC]  = low[4];
        s[`SXE_FLAG_Z]   = (r == `SXE_BYTE_ZERO);
        s[`SXE_FLAG_SW]  = sum[8] ^ sum7[7];
        s[`SXE_FLAG_SGC] = sum[8] ^ sum7[7] ^ r[7];
      end
      `SXE_OP_ANDA, `SXE_OP_ANDM:
      begin
        r = a.wreg & a.opnd;
        s[`SXE_FLAG_Z] = (r == `SXE_BYTE_ZERO);
      end
      `SXE_OP_CLR:
      begin
        r = `SXE_BYTE_ZERO;
      end
      `SXE_OP_CLRBIT:
      begin
        r = a.opnd;
        r[a.bit_sel] = 1'b0;
      end
      `SXE_OP_CPL, `SXE_OP_CPLA:
      begin
        r = ~a.opnd;
        s[`SXE_FLAG_Z] = (r == `SXE_BYTE_ZERO);
      end
      `SXE_OP_DAA:
      begin
        r = dsum[7:0];
        s[`SXE_FLAG_C] = dsum[8] | a.status[`SXE_FLAG_C];
      end
      `SXE_OP_DEC, `SXE_OP_DECA:
      begin
        r = a.opnd - `SXE_BYTE_ONE;
        s[`SXE_FLAG_Z] = (r == `SXE_BYTE_ZERO);
      end
      `SXE_OP_INC, `SXE_OP_INCA:
      begin
        r = a.opnd + `SXE_BYTE_ONE;
        s[`SXE_FLAG_Z] = (r == `SXE_BYTE_ZERO);
      end
      `SXE_OP_SKZLD:
      begin
        r = a.opnd;
      end
      default:
      begin
        r = a.wreg;
      end
    endcase
  end

  assign a.result     = r;
  assign a.status_new = s;

endmodule : sxe_alu

// >>> sxe_core.sv
/*
  sequencer for skip, table-read, exclusive-or and extended data operations.
  assumes decode presents one op at a time with op_valid and waits for
  op_done; data memory answers a read one cycle after dmem_rd; program
  memory answers one cycle after pmem_rd. all on core_clk.
*/
`timescale 1ns/1ps
`include "sxe_defines.svh"

// Functional notes
// - skip-zero-load copies byte, skips when zero
// - bit test skips when selected bit zero
// - page table read uses both pointer bytes
// - pre-increment low pointer, then page read
// - pre-increment low pointer, then last-page read
// - xor into working register, zero flag
// - xor written back to memory, zero flag
// - add with carry into working register
// - add with carry into memory
// - add without carry, either destination
// - and, either destination, zero flag only
// - byte clear writes zero, no flags
// - bit clear touches one bit only
// - complement memory byte, zero flag
// - complement into working register, memory kept
// - low nibble over nine or nibble carry adds six
// - high nibble over nine or carry adds sixty
// - decimal adjust writes memory, carry only
// - extended forms address any data section
module sxe_core
  import sxe_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        op_valid,
  input  wire logic [4:0]  op_code,
  input  wire logic        op_ext,
  input  wire logic [7:0]  op_addr,
  input  wire logic [1:0]  op_sect,
  input  wire logic [2:0]  op_bit,
  input  wire logic [7:0]  op_imm,
  input  wire logic [1:0]  cur_sect,
  input  wire logic [7:0]  dmem_rdata,
  input  wire logic [15:0] pmem_rdata,
  output logic             op_done,
  output logic             skip_next,
  output logic             dmem_rd,
  output logic             dmem_wr,
  output logic [9:0]       dmem_addr,
  output logic [7:0]       dmem_wdata,
  output logic             pmem_rd,
  output logic [15:0]      pmem_addr,
  output logic [7:0]       working_register,
  output logic [7:0]       status_flags,
  output logic [7:0]       table_high_latch,
  output logic [7:0]       table_pointer_low,
  output logic [7:0]       table_pointer_high
);

  // --------------------------------------------------------------------------
  // held request and state
  // --------------------------------------------------------------------------
  sxe_state_t state_q;
  sxe_op_t    op_q;
  logic [9:0] addr_q;
  logic [2:0] bit_q;
  logic [7:0] imm_q;
  logic [7:0] wreg_q;
  logic [7:0] stat_q;
  logic [7:0] tbh_q;
  logic [7:0] tpl_q;
  logic [7:0] tph_q;
  logic       done_q;
  logic       skip_q;
  logic       drd_q;
  logic       dwr_q;
  logic [7:0] dwd_q;
  logic       prd_q;
  logic [15:0] padr_q;
  logic       to_mem;
  logic       to_wreg;
  logic       is_table;
  logic       is_pre;
  logic       is_last;
  logic [7:0] tpl_use;

  sxe_alu_if alu_bus ();

  sxe_alu u_alu (
    .a (alu_bus)
  );

  assign alu_bus.op      = op_q;
  assign alu_bus.wreg    = wreg_q;
  assign alu_bus.opnd    = (op_q == `SXE_OP_XORI) ? imm_q : dmem_rdata;
  assign alu_bus.status  = stat_q;
  assign alu_bus.bit_sel = bit_q;

  // --------------------------------------------------------------------------
  // destination decode
  // --------------------------------------------------------------------------
  always_comb
  begin
    to_mem  = 1'b0;
    to_wreg = 1'b0;
    case (op_q)
      `SXE_OP_XORMEM, `SXE_OP_ADCM, `SXE_OP_ADDM, `SXE_OP_ANDM, `SXE_OP_CLR,
      `SXE_OP_CLRBIT, `SXE_OP_CPL, `SXE_OP_DAA, `SXE_OP_DEC, `SXE_OP_INC:
        to_mem = 1'b1;
      `SXE_OP_SKZLD, `SXE_OP_XORA, `SXE_OP_XORI, `SXE_OP_ADCA, `SXE_OP_ADDA,
      `SXE_OP_ANDA, `SXE_OP_CPLA, `SXE_OP_DECA, `SXE_OP_INCA:
        to_wreg = 1'b1;
      default:
        to_mem = 1'b0;
    endcase
  end

  assign is_table = (op_code >= `SXE_OP_TRD) && (op_code <= `SXE_OP_ITRDL);
  assign is_pre   = (op_code == `SXE_OP_ITRD) || (op_code == `SXE_OP_ITRDL);
  assign is_last  = (op_code == `SXE_OP_TRDL) || (op_code == `SXE_OP_ITRDL);
  // the incremented pointer addresses the fetch in the same cycle it is stored
  assign tpl_use  = is_pre ? tpl_q + `SXE_BYTE_ONE : tpl_q;

  // --------------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state_q <= SXE_IDLE;
      op_q    <= `SXE_OP_NOP;
      addr_q  <= 10'h000;
      bit_q   <= 3'h0;
      imm_q   <= `SXE_BYTE_ZERO;
      done_q  <= 1'b0;
      skip_q  <= 1'b0;
      drd_q   <= 1'b0;
      prd_q   <= 1'b0;
      padr_q  <= 16'h0000;
    end
    else
    begin
      done_q <= 1'b0;
      skip_q <= 1'b0;
      drd_q  <= 1'b0;
      prd_q  <= 1'b0;
      case (state_q)
        SXE_IDLE:
        begin
          if (op_valid)
          begin
            op_q   <= op_code;
            // extended forms carry their own section; base forms use current
            addr_q <= {op_ext ? op_sect : cur_sect, op_addr};
            bit_q  <= op_bit;
            imm_q  <= op_imm;
            if (is_table)
            begin
              prd_q   <= 1'b1;
              padr_q  <= {is_last ? `SXE_LAST_PAGE : tph_q, tpl_use};
              state_q <= SXE_TABLE_WAIT;
            end
            else if (op_code == `SXE_OP_XORI)
            begin
              // immediate operand is already held, no memory read needed
              state_q <= SXE_OPERAND;
            end
            else
            begin
              drd_q   <= 1'b1;
              state_q <= SXE_DATA_WAIT;
            end
          end
        end
        SXE_DATA_WAIT:
        begin
          // memory answers one cycle after the strobe; computing here
          // would use a stale byte and corrupt the flags for later ops
          state_q <= SXE_OPERAND;
        end
        SXE_TABLE_WAIT:
        begin
          // program word only stands in the cycle after the fetch strobe
          state_q <= SXE_TABLE;
        end
        SXE_OPERAND:
        begin
          if ((op_q == `SXE_OP_SKZLD && dmem_rdata == `SXE_BYTE_ZERO) ||
              (op_q == `SXE_OP_SZBIT && !dmem_rdata[bit_q]))
          begin
            skip_q  <= 1'b1;
            state_q <= SXE_SKIP;
          end
          else
          begin
            done_q  <= 1'b1;
            state_q <= SXE_IDLE;
          end
        end
        SXE_TABLE:
        begin
          done_q  <= 1'b1;
          state_q <= SXE_IDLE;
        end
        SXE_SKIP:
        begin
          // dummy slot while the skipped fetch is discarded
          done_q  <= 1'b1;
          state_q <= SXE_IDLE;
        end
        default:
          state_q <= SXE_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // data memory write port
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      dwr_q <= 1'b0;
      dwd_q <= `SXE_BYTE_ZERO;
    end
    else
    begin
      dwr_q <= 1'b0;
      if (state_q == SXE_OPERAND && to_mem)
      begin
        dwr_q <= 1'b1;
        dwd_q <= alu_bus.result;
      end
      else if (state_q == SXE_TABLE)
      begin
        dwr_q <= 1'b1;
        dwd_q <= pmem_rdata[7:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // working register and flags
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      wreg_q <= `SXE_WREG_RST;
      stat_q <= `SXE_STATUS_RST;
    end
    else if (state_q == SXE_OPERAND)
    begin
      if (to_wreg)
      begin
        wreg_q <= alu_bus.result;
      end
      stat_q <= alu_bus.status_new;
    end
  end

  // --------------------------------------------------------------------------
  // table pointer and latch
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      tpl_q <= `SXE_PTR_RST;
      tph_q <= `SXE_PTR_RST;
      tbh_q <= `SXE_BYTE_ZERO;
    end
    else
    begin
      if (state_q == SXE_IDLE && op_valid && is_table)
      begin
        tpl_q <= tpl_use;
      end
      if (state_q == SXE_TABLE)
      begin
        tbh_q <= pmem_rdata[15:8];
      end
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign op_done            = done_q;
  assign skip_next          = skip_q;
  assign dmem_rd            = drd_q;
  assign dmem_wr            = dwr_q;
  assign dmem_addr          = addr_q;
  assign dmem_wdata         = dwd_q;
  assign pmem_rd            = prd_q;
  assign pmem_addr          = padr_q;
  assign working_register   = wreg_q;
  assign status_flags       = stat_q;
  assign table_high_latch   = tbh_q;
  assign table_pointer_low  = tpl_q;
  assign table_pointer_high = tph_q;

endmodule : sxe_core

// >>> sxe_mem_model.sv
/*
  data and program memory model standing on the far side of sxe_core.
  assumes reads are answered one cycle after the strobe, on core_clk.
*/
`timescale 1ns/1ps
module sxe_mem_model (
  input  wire logic        core_clk,
  input  wire logic        dmem_rd,
  input  wire logic        dmem_wr,
  input  wire logic [9:0]  dmem_addr,
  input  wire logic [7:0]  dmem_wdata,
  input  wire logic        pmem_rd,
  input  wire logic [15:0] pmem_addr,
  output logic      [7:0]  dmem_rdata,
  output logic      [15:0] pmem_rdata
);
  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [7:0] mem [0:1023];

  initial dmem_rdata = 8'h5a;
  initial pmem_rdata = 16'ha55a;

  // outside the answer cycle the buses flip every cycle, so a core that
  // samples late sees garbage instead of a lucky stale value
  always @(posedge core_clk)
  begin
    dmem_rdata <= dmem_rd ? mem[dmem_addr] : ~dmem_rdata;
    pmem_rdata <= pmem_rd ? {~pmem_addr[7:0], pmem_addr[15:8] ^ pmem_addr[7:0]} : ~pmem_rdata;
    if (dmem_wr)
      mem[dmem_addr] <= dmem_wdata;
  end
endmodule : sxe_mem_model

// >>> sxe_core_chk.sv
/*
  concurrent checks on the ports of sxe_core.
  assumes one op in flight at a time and a single core_clk domain.
*/
`timescale 1ns/1ps
`include "sxe_defines.svh"
module sxe_core_chk (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        op_valid,
  input wire logic [4:0]  op_code,
  input wire logic        op_ext,
  input wire logic [7:0]  op_addr,
  input wire logic [1:0]  op_sect,
  input wire logic [1:0]  cur_sect,
  input wire logic        op_done,
  input wire logic        skip_next,
  input wire logic        dmem_rd,
  input wire logic        dmem_wr,
  input wire logic [9:0]  dmem_addr,
  input wire logic [7:0]  dmem_wdata,
  input wire logic        pmem_rd,
  input wire logic [15:0] pmem_addr,
  input wire logic [7:0]  working_register,
  input wire logic [7:0]  status_flags,
  input wire logic [7:0]  table_pointer_low,
  input wire logic [7:0]  table_pointer_high
);
  // ----------------------------------------------------------------------
  // op tracking
  // ----------------------------------------------------------------------
  logic       busy_q;
  logic [4:0] op_q;
  logic [9:0] loc_q;
  logic [7:0] flags_q;
  logic [7:0] ptr_q;
  logic       take;

  assign take = op_valid && (!busy_q || op_done);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      busy_q <= 1'b0;
    else if (take)
      busy_q <= 1'b1;
    else if (op_done)
      busy_q <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (take)
    begin
      op_q    <= op_code;
      loc_q   <= {op_ext ? op_sect : cur_sect, op_addr};
      flags_q <= status_flags;
      ptr_q   <= table_pointer_low;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_finish;
    ##[2:4] op_done;
  endsequence
  sequence s_skip_end;
    op_done ##1 !op_done;
  endsequence

  a_done_bounded: assert property (take |-> s_finish)
    else $error("operation did not finish in time");
  a_skip_then_done: assert property (skip_next |=> s_skip_end)
    else $error("skip not followed by one completion");
  a_skip_source: assert property (skip_next |-> op_q inside {`SXE_OP_SKZLD, `SXE_OP_SZBIT})
    else $error("skip raised by a non-skip op");
  a_mem_location: assert property ((dmem_rd || dmem_wr) |-> dmem_addr == loc_q)
    else $error("data access at wrong location");
  a_clear_zero: assert property (dmem_wr && op_q == `SXE_OP_CLR |-> dmem_wdata == 8'h00)
    else $error("clear wrote nonzero");
  a_keep_flags: assert property (op_done && op_q inside {`SXE_OP_SKZLD, `SXE_OP_SZBIT, `SXE_OP_TRD, `SXE_OP_TRDL,
    `SXE_OP_ITRD, `SXE_OP_ITRDL, `SXE_OP_CLR, `SXE_OP_CLRBIT} |-> status_flags == flags_q)
    else $error("flags changed by flagless op");
  a_zero_only: assert property (op_done && op_q inside {`SXE_OP_XORA, `SXE_OP_XORI, `SXE_OP_XORMEM, `SXE_OP_ANDA,
    `SXE_OP_ANDM, `SXE_OP_CPL, `SXE_OP_CPLA, `SXE_OP_DEC, `SXE_OP_DECA, `SXE_OP_INC, `SXE_OP_INCA}
    |-> (status_flags & 8'hfb) == (flags_q & 8'hfb))
    else $error("logic op touched a flag other than zero");
  a_zero_flag: assert property (op_done && op_q inside {`SXE_OP_XORA, `SXE_OP_XORI, `SXE_OP_ANDA, `SXE_OP_CPLA,
    `SXE_OP_DECA, `SXE_OP_INCA} |-> status_flags[`SXE_FLAG_Z] == (working_register == 8'h00))
    else $error("zero flag disagrees with result");
  a_daa_carry: assert property (op_done && op_q == `SXE_OP_DAA
    |-> status_flags[7:1] == flags_q[7:1] && (status_flags[0] || !flags_q[0]))
    else $error("decimal adjust changed a flag wrongly");
  a_wreg_only: assert property (dmem_wr |-> !(op_q inside {`SXE_OP_CPLA, `SXE_OP_DECA, `SXE_OP_INCA,
    `SXE_OP_XORA, `SXE_OP_XORI, `SXE_OP_ADCA, `SXE_OP_ADDA, `SXE_OP_ANDA}))
    else $error("register-only op wrote memory");
  a_page_addr: assert property (pmem_rd && op_q inside {`SXE_OP_TRD, `SXE_OP_ITRD}
    |-> pmem_addr == {table_pointer_high, table_pointer_low})
    else $error("page table address wrong");
  a_last_addr: assert property (pmem_rd && op_q inside {`SXE_OP_TRDL, `SXE_OP_ITRDL}
    |-> pmem_addr == {`SXE_LAST_PAGE, table_pointer_low})
    else $error("last page table address wrong");
  a_preinc_step: assert property (pmem_rd && op_q inside {`SXE_OP_ITRD, `SXE_OP_ITRDL}
    |-> table_pointer_low == ptr_q + 8'h01)
    else $error("pointer not advanced before read");
endmodule : sxe_core_chk

bind sxe_core sxe_core_chk chk_u (.core_clk, .rst_n, .op_valid, .op_code, .op_ext, .op_addr, .op_sect,
  .cur_sect, .op_done, .skip_next, .dmem_rd, .dmem_wr, .dmem_addr, .dmem_wdata, .pmem_rd, .pmem_addr,
  .working_register, .status_flags, .table_pointer_low, .table_pointer_high);

// >>> sxe_core_bench.sv
/*
  self-checking bench for sxe_core: skips, table reads, extended ops.
  assumes sxe_mem_model on the memory side and the bound checker.
*/
`timescale 1ns/1ps
`include "sxe_defines.svh"
module sxe_core_bench;
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic        op_valid = 1'b0;
  logic [4:0]  op_code  = 5'h00;
  logic        op_ext   = 1'b0;
  logic [7:0]  op_addr  = 8'h00;
  logic [1:0]  op_sect  = 2'h3;
  logic [2:0]  op_bit   = 3'h3;
  logic [7:0]  op_imm   = 8'h00;
  logic [1:0]  cur_sect = 2'h1;
  logic [7:0]  dmem_rdata, dmem_wdata, working_register, status_flags;
  logic [7:0]  table_high_latch, table_pointer_low, table_pointer_high;
  logic [15:0] pmem_rdata, pmem_addr;
  logic [9:0]  dmem_addr;
  logic        op_done, skip_next, dmem_rd, dmem_wr, pmem_rd, skip_seen;
  int          num_errors  = 0;
  int          comparisons = 0;
  int          cycles      = 0;

  initial forever #4 core_clk = ~core_clk;

  sxe_core dut_u (.core_clk, .rst_n, .op_valid, .op_code, .op_ext, .op_addr, .op_sect, .op_bit, .op_imm,
    .cur_sect, .dmem_rdata, .pmem_rdata, .op_done, .skip_next, .dmem_rd, .dmem_wr, .dmem_addr, .dmem_wdata,
    .pmem_rd, .pmem_addr, .working_register, .status_flags, .table_high_latch, .table_pointer_low,
    .table_pointer_high);
  sxe_mem_model model_u (.core_clk, .dmem_rd, .dmem_wr, .dmem_addr, .dmem_wdata, .pmem_rd, .pmem_addr,
    .dmem_rdata, .pmem_rdata);

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic print_verdict;
    if (num_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // results are read at the falling edge so the memory write has landed
  task automatic issue(input logic [4:0] op, input logic [7:0] a, input logic ext);
    int n;
    @(posedge core_clk);
    op_code  <= op;
    op_addr  <= a;
    op_ext   <= ext;
    op_valid <= 1'b1;
    @(posedge core_clk);
    op_valid <= 1'b0;
    skip_seen = 1'b0;
    n = 0;
    while (op_done !== 1'b1 && n < 8)
    begin
      @(posedge core_clk);
      skip_seen = skip_seen | (skip_next === 1'b1);
      n++;
    end
    check("done", {7'h00, op_done}, 8'h01);
    @(negedge core_clk);
  endtask : issue

  task automatic step(input logic [4:0] op, input logic [7:0] m, input logic [7:0] exp,
                      input logic [7:0] f, input bit to_mem);
    model_u.mem[10'h340] = m;
    op_imm <= m;
    issue(op, 8'h40, 1'b1);
    check("result", to_mem ? model_u.mem[10'h340] : working_register, exp);
    check("flags", status_flags, f);
  endtask : step

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_skip;
    logic [7:0] v [4] = '{8'h00, 8'h3c, 8'hf7, 8'h08};
    for (int i = 0; i < 4; i++)
    begin
      model_u.mem[10'h110] = v[i];
      issue(i < 2 ? `SXE_OP_SKZLD : `SXE_OP_SZBIT, 8'h10, 1'b0);
      check("skip", {7'h00, skip_seen}, {7'h00, i == 0 || i == 2});
      if (i < 2)
        check("wreg", working_register, v[i]);
      check("flags", status_flags, 8'h00);
    end
  endtask : t_skip

  task automatic t_table;
    logic [4:0] ops [4] = '{`SXE_OP_TRD, `SXE_OP_ITRD, `SXE_OP_TRDL, `SXE_OP_ITRDL};
    logic [7:0] p;
    logic [7:0] a;
    p = 8'h00;
    for (int i = 0; i < 4; i++)
    begin
      if (i[0])
        p = p + 8'h01;
      a = 8'h20 + 8'(i);
      issue(ops[i], a, 1'b1);
      check("table low", model_u.mem[{2'h3, a}], (i[1] ? 8'hff : 8'h00) ^ p);
      check("table high", table_high_latch, ~p);
      check("pointer", table_pointer_low, p);
    end
  endtask : t_table

  task automatic t_ops;
    step(`SXE_OP_SKZLD,  8'h7f, 8'h7f, 8'h00, 1'b0);
    step(`SXE_OP_ADDA,   8'h01, 8'h80, 8'h0a, 1'b0);
    step(`SXE_OP_DAA,    8'h33, 8'h86, 8'h0a, 1'b1);
    step(`SXE_OP_ADDA,   8'h25, 8'ha5, 8'h10, 1'b0);
    step(`SXE_OP_DAA,    8'h33, 8'h05, 8'h11, 1'b1);
    step(`SXE_OP_ADCM,   8'h80, 8'h26, 8'h19, 1'b1);
    step(`SXE_OP_ADCA,   8'h5a, 8'h00, 8'h07, 1'b0);
    step(`SXE_OP_ADDM,   8'h90, 8'h90, 8'h10, 1'b1);
    step(`SXE_OP_ANDA,   8'h0f, 8'h00, 8'h14, 1'b0);
    step(`SXE_OP_XORI,   8'ha5, 8'ha5, 8'h10, 1'b0);
    step(`SXE_OP_ANDM,   8'h7d, 8'h25, 8'h10, 1'b1);
    step(`SXE_OP_XORA,   8'ha5, 8'h00, 8'h14, 1'b0);
    step(`SXE_OP_XORMEM, 8'h3c, 8'h3c, 8'h10, 1'b1);
    step(`SXE_OP_CPL,    8'hff, 8'h00, 8'h14, 1'b1);
    step(`SXE_OP_CPLA,   8'h0f, 8'hf0, 8'h10, 1'b0);
    step(`SXE_OP_DEC,    8'h01, 8'h00, 8'h14, 1'b1);
    step(`SXE_OP_DECA,   8'h00, 8'hff, 8'h10, 1'b0);
    step(`SXE_OP_INC,    8'hff, 8'h00, 8'h14, 1'b1);
    step(`SXE_OP_INCA,   8'h41, 8'h42, 8'h10, 1'b0);
    step(`SXE_OP_CLR,    8'h77, 8'h00, 8'h10, 1'b1);
    step(`SXE_OP_CLRBIT, 8'hff, 8'hf7, 8'h10, 1'b1);
  endtask : t_ops

  // a hang is cut short well beyond the roughly 150 cycles the run needs
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      print_verdict();
    end
  end

  initial
  begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    t_skip();
    t_table();
    t_ops();
    print_verdict();
  end
endmodule : sxe_core_bench
